// *** design/capture_pkg.sv ***
// Shared constants for the dual-channel capture buffer
package capture_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32768;
  localparam int MAX_WRITE_MSPS = 133;
  localparam int SYS_CLK_MHZ = 100;
  localparam int DELAY_TAPS = 3;
  localparam int DELAY_SEL_W = 2;
  localparam int NUM_CH = 2;
  // Positions inside the synchroniser vector
  localparam int POS_LOW_N = 0;
  localparam int POS_HIGH_N = 1;
  localparam int POS_OE1 = 2;
  localparam int POS_OE2 = 3;
  localparam int POS_MRS = 4;
  localparam int POS_RD1 = 5;
  localparam int POS_RD2 = 6;
  localparam int POS_CAP1 = 7;
  localparam int POS_CAP2 = 8;
  localparam int POS_DATA1 = 9;
  localparam int POS_DATA2 = POS_DATA1 + DATA_W;
  localparam int SYNC_W = POS_DATA2 + DATA_W;
  // Byte strobes idle high, everything else idles low
  localparam logic [SYNC_W-1:0] SYNC_RESET = 41'h0_0000_0003;
endpackage

// *** design/fifo_channel_if.sv ***
// Connection between the capture control and one channel FIFO
`timescale 1ns/1ps
interface fifo_channel_if #(parameter int DATA_W = 16);
  logic wr_en;
  logic [DATA_W-1:0] wr_data;
  logic rd_en;
  logic [DATA_W-1:0] rd_data;
  logic clear;
  logic full;
  logic empty;
  modport ctrl(output wr_en, output wr_data, output rd_en, output clear,
               input rd_data, input full, input empty);
  modport fifo(input wr_en, input wr_data, input rd_en, input clear,
               output rd_data, output full, output empty);
endinterface

// *** design/capture_fifo.sv ***
// One channel of sample storage: write-ordered FIFO with pointer clear
`timescale 1ns/1ps
module capture_fifo #(
  parameter int DATA_W = capture_pkg::DATA_W,
  parameter int DEPTH = capture_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  fifo_channel_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] fill_q;
  logic [DATA_W-1:0] rd_data_q;
  logic wr_ok;
  logic rd_ok;

  assign port.full = (fill_q == DEPTH_L);
  assign port.empty = (fill_q == '0);
  // A full FIFO ignores writes so the record start is never overwritten
  assign wr_ok = port.wr_en && !port.full && !port.clear;
  assign rd_ok = port.rd_en && !port.empty && !port.clear;
  assign port.rd_data = rd_data_q;

  always_ff @(posedge clk_sys_in) begin
    if (wr_ok) begin
      mem[wr_ptr_q] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || port.clear) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (wr_ok) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (rd_ok) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || port.clear) begin
      fill_q <= '0;
    end else if (wr_ok && !rd_ok) begin
      fill_q <= fill_q + 1'b1;
    end else if (rd_ok && !wr_ok) begin
      fill_q <= fill_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rd_data_q <= '0;
    end else if (rd_ok) begin
      rd_data_q <= mem[rd_ptr_q];
    end
  end
endmodule

// *** design/dual_adc_capture_buffer.sv ***
// Two-channel capture buffer with byte-wide host readout
//
// How it works
// - Each channel stores sample words on its write clock into a record of up to 32K words.
// - Master reset from the host clears both FIFO pointers and restarts acquisition.
// - Each 16-bit word leaves as two bytes, high or low picked by two read-select strobes.
// - The channel 1 output enable is either forced on or taken from the host, by mode.
// - Each write clock may be used true (default) or inverted to line up with the data.
// - Optional extra delay stages sit in the write-clock path and are bypassed by default.
// - In interleaved capture channel 2 may only write after channel 1 stored its first word.
`timescale 1ns/1ps
module dual_adc_capture_buffer #(
  parameter int DEPTH = capture_pkg::FIFO_DEPTH,
  parameter int DELAY_TAPS = capture_pkg::DELAY_TAPS
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic capture_clock_ch1_in,
  input wire logic capture_clock_ch2_in,
  input wire logic [capture_pkg::DATA_W-1:0] capture_data_ch1_in,
  input wire logic [capture_pkg::DATA_W-1:0] capture_data_ch2_in,
  input wire logic shared_clock_mode_in,
  input wire logic clock_invert_ch1_in,
  input wire logic clock_invert_ch2_in,
  input wire logic [capture_pkg::DELAY_SEL_W-1:0] extra_delay_ch1_in,
  input wire logic [capture_pkg::DELAY_SEL_W-1:0] extra_delay_ch2_in,
  input wire logic interleave_mode_in,
  input wire logic read_clock_ch1_in,
  input wire logic read_clock_ch2_in,
  input wire logic master_pointer_reset_in,
  input wire logic byte_select_strobe_high_n_in,
  input wire logic byte_select_strobe_low_n_in,
  input wire logic output_enable_ch1_in,
  input wire logic output_enable_ch2_in,
  input wire logic oe_ch1_forced_in,
  output logic [capture_pkg::BYTE_W-1:0] host_data_out,
  output logic host_data_oe_out,
  output logic full_ch1_out,
  output logic full_ch2_out,
  output logic empty_ch1_out,
  output logic empty_ch2_out
);
  localparam int DW = capture_pkg::DATA_W;
  localparam int NCH = capture_pkg::NUM_CH;

  // Every pin in pins_raw crosses two flops first; the mode and option inputs do not. Edges are found on the 100 MHz clock, so a
  // source clock must stay below half that rate here even though storage allows more.
  logic [capture_pkg::SYNC_W-1:0] pins_raw;
  logic [capture_pkg::SYNC_W-1:0] pins_meta_q;
  logic [capture_pkg::SYNC_W-1:0] pins_sync_q;

  assign pins_raw = {capture_data_ch2_in, capture_data_ch1_in,
                     capture_clock_ch2_in, capture_clock_ch1_in,
                     read_clock_ch2_in, read_clock_ch1_in,
                     master_pointer_reset_in,
                     output_enable_ch2_in, output_enable_ch1_in,
                     byte_select_strobe_high_n_in, byte_select_strobe_low_n_in};

  for (genvar i = 0; i < capture_pkg::SYNC_W; i++) begin : g_sync
    always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
        pins_meta_q[i] <= capture_pkg::SYNC_RESET[i];
        pins_sync_q[i] <= capture_pkg::SYNC_RESET[i];
      end else begin
        pins_meta_q[i] <= pins_raw[i];
        pins_sync_q[i] <= pins_meta_q[i];
      end
    end
  end

  logic master_reset;
  logic strobe_high;
  logic strobe_low;
  logic [NCH-1:0] cap_clk;
  logic [NCH-1:0] invert;
  logic [NCH-1:0] rd_clk;
  logic [NCH-1:0] oe_eff;
  logic [capture_pkg::DELAY_SEL_W-1:0] delay_sel [NCH];
  logic [DW-1:0] cap_data [NCH];
  logic [DW-1:0] rd_word [NCH];
  logic [NCH-1:0] full;
  logic [NCH-1:0] empty;
  logic [NCH-1:0] wr_strobe;
  logic first_write_ch1_q;

  assign master_reset = pins_sync_q[capture_pkg::POS_MRS];
  assign strobe_high = !pins_sync_q[capture_pkg::POS_HIGH_N];
  assign strobe_low = !pins_sync_q[capture_pkg::POS_LOW_N];
  assign cap_clk[0] = pins_sync_q[capture_pkg::POS_CAP1];
  // In shared clock mode the channel 1 source clock feeds both channels
  assign cap_clk[1] = shared_clock_mode_in ? pins_sync_q[capture_pkg::POS_CAP1]
                                           : pins_sync_q[capture_pkg::POS_CAP2];
  assign invert = {clock_invert_ch2_in, clock_invert_ch1_in};
  assign rd_clk = {pins_sync_q[capture_pkg::POS_RD2], pins_sync_q[capture_pkg::POS_RD1]};
  assign oe_eff[0] = oe_ch1_forced_in || pins_sync_q[capture_pkg::POS_OE1];
  assign oe_eff[1] = pins_sync_q[capture_pkg::POS_OE2];
  assign delay_sel[0] = extra_delay_ch1_in;
  assign delay_sel[1] = extra_delay_ch2_in;
  assign cap_data[0] = pins_sync_q[capture_pkg::POS_DATA1 +: DW];
  assign cap_data[1] = pins_sync_q[capture_pkg::POS_DATA2 +: DW];

  logic [DW-1:0] sel_word;
  logic [capture_pkg::BYTE_W-1:0] host_data_q;
  logic host_oe_q;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic wr_level;
    logic wr_level_q;
    logic wr_edge;
    logic [DELAY_TAPS-1:0] delay_q;
    logic rd_level_q;
    logic wr_allowed;
    logic wr_pulse;
    logic rd_edge;

    fifo_channel_if #(.DATA_W(DW)) fif ();

    assign wr_level = cap_clk[c];
    // Inverted use stores on the falling source edge instead of the rising one
    assign wr_edge = invert[c] ? (!wr_level && wr_level_q)
                               : (wr_level && !wr_level_q);
    assign rd_edge = rd_clk[c] && !rd_level_q;

    // Both detectors rest low like the clocks, so reset never fakes an edge
    always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
        wr_level_q <= 1'b0;
        rd_level_q <= 1'b0;
      end else begin
        wr_level_q <= wr_level;
        rd_level_q <= rd_clk[c];
      end
    end

    // Each tap holds the store strobe back by one system cycle; needs two taps at least
    always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
        delay_q <= '0;
      end else begin
        delay_q <= {delay_q[DELAY_TAPS-2:0], wr_edge};
      end
    end

    // Select zero bypasses the chain
    always_comb begin
      wr_pulse = wr_edge;
      for (int t = 1; t <= DELAY_TAPS; t++) begin
        if (int'(delay_sel[c]) == t) begin
          wr_pulse = delay_q[t-1];
        end
      end
    end

    assign wr_strobe[c] = wr_pulse;

    if (c == 0) begin : g_lead
      assign wr_allowed = 1'b1;
    end else begin : g_follow
      // In interleave mode channel 2 holds off until channel 1 has stored a word
      assign wr_allowed = !interleave_mode_in || first_write_ch1_q;
    end

    assign fif.wr_en = wr_strobe[c] && wr_allowed;
    assign fif.wr_data = cap_data[c];
    // A channel only advances while the host has it selected
    assign fif.rd_en = rd_edge && oe_eff[c];
    assign fif.clear = master_reset;
    assign rd_word[c] = fif.rd_data;
    assign full[c] = fif.full;
    assign empty[c] = fif.empty;

    capture_fifo #(
      .DATA_W(DW),
      .DEPTH(DEPTH)
    ) fifo_u (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .port(fif)
    );
  end

  // Set only by a word that really lands; master reset blocks that write, and
  // its clear wins when set and clear meet in one cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || master_reset) begin
      first_write_ch1_q <= 1'b0;
    end else if (interleave_mode_in && wr_strobe[0] && !full[0]) begin
      first_write_ch1_q <= 1'b1;
    end
  end

  // Channel 1 wins if the host enables both at once
  always_comb begin
    if (oe_eff[0]) begin
      sel_word = rd_word[0];
    end else begin
      sel_word = rd_word[1];
    end
  end

  // High byte wins if both strobes are active
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      host_data_q <= '0;
    end else if (strobe_high) begin
      host_data_q <= sel_word[DW-1 -: capture_pkg::BYTE_W];
    end else if (strobe_low) begin
      host_data_q <= sel_word[capture_pkg::BYTE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      host_oe_q <= 1'b0;
    end else begin
      host_oe_q <= (|oe_eff) && (strobe_high || strobe_low);
    end
  end

  assign host_data_out = host_data_q;
  assign host_data_oe_out = host_oe_q;
  assign full_ch1_out = full[0];
  assign full_ch2_out = full[1];
  assign empty_ch1_out = empty[0];
  assign empty_ch2_out = empty[1];
endmodule

// *** dv/capture_buffer_chk.sv ***
// Port assertions for the capture buffer
`timescale 1ns/1ps
module capture_buffer_chk (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic capture_clock_ch1_in,
  input wire logic master_pointer_reset_in,
  input wire logic output_enable_ch1_in,
  input wire logic output_enable_ch2_in,
  input wire logic oe_ch1_forced_in,
  input wire logic host_data_oe_out,
  input wire logic full_ch1_out,
  input wire logic full_ch2_out,
  input wire logic empty_ch1_out,
  input wire logic empty_ch2_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  AST_CLR_CH1: assert property (master_pointer_reset_in[*3] |-> ##[0:8] empty_ch1_out)
    else $error("ch1 not cleared");
  AST_CLR_CH2: assert property (master_pointer_reset_in[*3] |-> ##[0:8] empty_ch2_out)
    else $error("ch2 not cleared");
  AST_CLR_HOLD: assert property (master_pointer_reset_in[*8] |-> !full_ch1_out && !full_ch2_out)
    else $error("full during reset");
  AST_FLAGS_CH1: assert property (!(full_ch1_out && empty_ch1_out))
    else $error("ch1 full and empty");
  AST_FLAGS_CH2: assert property (!(full_ch2_out && empty_ch2_out))
    else $error("ch2 full and empty");
  // Eight quiet cycles let any synchronised write land first
  AST_NO_WRITE: assert property ($stable(capture_clock_ch1_in)[*8] ##0 empty_ch1_out |=> empty_ch1_out)
    else $error("ch1 filled without clock");
  AST_NO_FILL: assert property ($stable(capture_clock_ch1_in)[*8] ##0 !full_ch1_out |=> !full_ch1_out)
    else $error("ch1 full without clock");
  AST_BUS_OFF: assert property ((!output_enable_ch1_in && !output_enable_ch2_in && !oe_ch1_forced_in)[*8] |-> !host_data_oe_out)
    else $error("bus driven unselected");
  cover property (full_ch1_out);
  cover property (full_ch2_out);
  cover property ($rose(host_data_oe_out));
endmodule
bind dual_adc_capture_buffer capture_buffer_chk chk_u (.clk_sys_in, .rst_n_in,
  .capture_clock_ch1_in, .master_pointer_reset_in, .output_enable_ch1_in,
  .output_enable_ch2_in, .oe_ch1_forced_in, .host_data_oe_out, .full_ch1_out,
  .full_ch2_out, .empty_ch1_out, .empty_ch2_out);

// *** dv/adc_source_model.sv ***
// Converter-side source: capture clock with a counting sample word
`timescale 1ns/1ps
module adc_source_model #(
  parameter logic [15:0] BASE = 16'h0000
) (
  input wire logic run_in,
  output logic clk_out,
  output logic [15:0] data_out
);
  logic [15:0] cnt;
  initial begin
    clk_out = 1'h0;
    cnt = 16'h0000;
    data_out = BASE;
    forever begin
      if (run_in) begin
        data_out = BASE + cnt;
        #80 clk_out = 1'h1;
        #80 clk_out = 1'h0;
        cnt = cnt + 16'h0001;
      end else begin
        // Clock stands still; data keeps changing so stale words never match
        cnt = 16'h0000;
        data_out = ~data_out;
        #80;
      end
    end
  end
endmodule

// *** dv/test_dual_adc_capture_buffer.sv ***
// Self-checking bench for the capture buffer
`timescale 1ns/1ps
module test_dual_adc_capture_buffer;
  localparam int DEPTH = 8;
  logic clk_sys_in = 1'h0, rst_n_in = 1'h0, run = 1'h0, ilv = 1'h0, master_pointer_reset = 1'h0, frc = 1'h0;
  logic shr = 1'h0, inv1 = 1'h0;
  logic rd1 = 1'h0, rd2 = 1'h0, hi_n = 1'h1, lo_n = 1'h1, oe1 = 1'h0, oe2 = 1'h0;
  logic cc1, cc2, hoe, f1, f2, e1, e2;
  logic [15:0] d1, d2;
  logic [7:0] hd;
  int err_count = 0;
  int samples_checked = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  adc_source_model #(.BASE(16'h1200)) src1_u (.run_in(run), .clk_out(cc1), .data_out(d1));
  // Idle in shared mode, so only the shared clock can fill channel 2
  adc_source_model #(.BASE(16'hA500)) src2_u (.run_in(run && !shr), .clk_out(cc2), .data_out(d2));
  dual_adc_capture_buffer #(.DEPTH(DEPTH)) dut_u (.clk_sys_in, .rst_n_in,
    .capture_clock_ch1_in(cc1), .capture_clock_ch2_in(cc2), .capture_data_ch1_in(d1),
    .capture_data_ch2_in(d2), .shared_clock_mode_in(shr), .clock_invert_ch1_in(inv1),
    .clock_invert_ch2_in(1'h0), .extra_delay_ch1_in(2'h0), .extra_delay_ch2_in(2'h0),
    .interleave_mode_in(ilv), .read_clock_ch1_in(rd1), .read_clock_ch2_in(rd2),
    .master_pointer_reset_in(master_pointer_reset), .byte_select_strobe_high_n_in(hi_n),
    .byte_select_strobe_low_n_in(lo_n), .output_enable_ch1_in(oe1),
    .output_enable_ch2_in(oe2), .oe_ch1_forced_in(frc), .host_data_out(hd),
    .host_data_oe_out(hoe), .full_ch1_out(f1), .full_ch2_out(f2), .empty_ch1_out(e1),
    .empty_ch2_out(e2));
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // Exact word count is loose, so the 12-word fill overruns the depth
  task automatic capture(input int n);
    run = 1'h1;
    #(160 * n + 40);
    wait_cyc(1);
    run = 1'h0;
    wait_cyc(24);
  endtask
  task automatic read_word(input logic ch, input logic [15:0] exp);
    logic [15:0] got;
    rd1 = !ch;
    rd2 = ch;
    wait_cyc(8);
    rd1 = 1'h0;
    rd2 = 1'h0;
    wait_cyc(8);
    hi_n = 1'h0;
    wait_cyc(8);
    got[15:8] = hd;
    hi_n = 1'h1;
    lo_n = 1'h0;
    wait_cyc(8);
    got[7:0] = hd;
    lo_n = 1'h1;
    wait_cyc(8);
    cmp("host word", exp, got);
  endtask
  initial begin
    wait_cyc(16);
    rst_n_in = 1'h1;
    wait_cyc(4);
    cmp("empty flags", 16'h0003, {14'h0000, e2, e1});
    capture(12);
    cmp("full flags", 16'h0003, {14'h0000, f2, f1});
    frc = 1'h1;
    for (int i = 0; i < DEPTH; i++) begin
      read_word(1'h0, 16'h1200 + 16'(i));
    end
    frc = 1'h0;
    oe2 = 1'h1;
    for (int i = 0; i < DEPTH; i++) begin
      read_word(1'h1, 16'hA500 + 16'(i));
    end
    oe2 = 1'h0;
    cmp("drained flags", 16'h0003, {14'h0000, e2, e1});
    // Inverted channel 1 stores on the falling edge, where the next word appears
    shr = 1'h1;
    inv1 = 1'h1;
    capture(3);
    cmp("shared fill flags", 16'h0000, {14'h0000, e2, e1});
    frc = 1'h1;
    read_word(1'h0, 16'h1201);
    frc = 1'h0;
    shr = 1'h0;
    inv1 = 1'h0;
    master_pointer_reset = 1'h1;
    wait_cyc(8);
    master_pointer_reset = 1'h0;
    wait_cyc(4);
    cmp("cleared flags", 16'h0003, {14'h0000, e2, e1});
    ilv = 1'h1;
    oe1 = 1'h1;
    capture(3);
    read_word(1'h0, 16'h1200);
    // Both sources edge together, so channel 2 misses its first word
    oe1 = 1'h0;
    oe2 = 1'h1;
    read_word(1'h1, 16'hA501);
    oe2 = 1'h0;
    conclude();
  end
  initial begin
    #200000;
    err_count++;
    conclude();
  end
endmodule
